// *** common/esc_seq_regs.vh ***
// Purpose: Register indices, fields, masks and resets of the sequencer bank.
// Assumes: Eight-bit sequencer data port with an eight-bit index.
// Notes:   Masks mark stored bits; others read zero.
`ifndef ESC_SEQ_REGS_VH
`define ESC_SEQ_REGS_VH
`define ESC_IDX_UNLOCK 8'h08
`define ESC_IDX_POLICY 8'h09
`define ESC_IDX_MEMBUS 8'h0A
`define ESC_IDX_FEATCLK 8'h0B
`define ESC_IDX_FEATSYNC 8'h0D
`define ESC_IDX_MPLL_LO 8'h10
`define ESC_IDX_MPLL_HI 8'h11
`define ESC_IDX_PPLL_LO 8'h12
`define ESC_IDX_PPLL_HI 8'h13
`define ESC_IDX_SYNTH1 8'h14
`define ESC_IDX_SYNTH2 8'h15
`define ESC_IDX_EXT_FIRST 8'h08
`define ESC_IDX_EXT_LAST 8'h1C
`define ESC_MSK_UNLOCK 8'h0F
`define ESC_MSK_POLICY 8'h80
`define ESC_MSK_MEMBUS 8'hA0
`define ESC_MSK_FEATCLK 8'hF3
`define ESC_MSK_FEATSYNC 8'hF1
`define ESC_MSK_SEVEN 8'h7F
`define ESC_UNLOCK_KEY 4'h6
`define ESC_B_MMIO_EXCLUSIVE_SELECT 7
`define ESC_B_BUS_KEEP 5
`define ESC_B_SHORT_WR 7
`define ESC_B_DOT_EXT 0
`define ESC_B_AFP_LATCH 1
`define ESC_B_FEAT_EN 0
`define ESC_B_PIX_PD 0
`define ESC_B_MEM_PD 1
`define ESC_B_CNT_EN 2
`define ESC_B_CNT_SEL 3
`define ESC_B_CNT_CLR 4
`define ESC_B_ALT_FLOAT 5
`define ESC_B_MEM_EXT 6
`define ESC_B_PIX_EXT 7
`define ESC_B_MEM_LOAD 0
`define ESC_B_PIX_LOAD 1
`define ESC_B_IMM_LOAD 5
`define ESC_FMT_8 4'h0
`define ESC_FMT_15 4'h3
`define ESC_FMT_16 4'h5
`define ESC_FORCE_NORMAL 2'h0
`define ESC_FORCE_LOW 2'h1
`define ESC_FORCE_HIGH 2'h2
`define ESC_RST_ZERO 8'h00
`define ESC_RST_MPLL_LO 8'h21
`define ESC_RST_MPLL_HI 8'h3F
`define ESC_WR_LONG 2'h3
`define ESC_WR_SHORT 2'h2
`endif

// *** hw/esc_seq_ctrl.v ***
// Purpose: Extended sequencer register bank with clock synthesizer controls.
// Assumes: core_clk is the memory clock; VGA-side inputs share it.
// Notes:   Summary of operation follows.
// Summary of operation
// RULE1: Low nibble 0110 in the unlock register opens every extended register.
// RULE2: Mmio_exclusive_select bit, with MMIO enabled, blocks port access to extended registers.
// RULE3: Bus drive keep bit 0 drives data bus only when needed; 1 always.
// RULE4: Upper data bus bits 63 to 29 hold the last driven value.
// RULE5: Short write bit selects two-clock writes; clear gives three-clock writes.
// RULE6: Dot source bit picks internal dot clock or the video clock input.
// RULE7: Feature port latch bit picks video clock or video clock input for latching.
// RULE8: Colour format code 0, 3, 5 selects 8, 15, 16 bit; others reserved.
// RULE9: Feature enable drives its pin low and hands pin directions to direction inputs.
// RULE10: Horizontal sync force: normal, held low, held high; code 3 reserved.
// RULE11: Vertical sync force: normal, held low, held high; code 3 reserved.
// RULE12: Memory clock parameters reset to values giving 45 MHz.
// RULE13: Memory input divider in low bits 4-0, feedback divider high bits 6-0.
// RULE14: Memory output range sits in low register bits 6-5.
// RULE15: Memory parameters load only on delayed-load bit 0 or immediate bit 5.
// RULE16: Enhanced pixel parameters feed the pixel PLL only when clock select is 11.
// RULE17: Pixel input divider bits 4-0, range bits 7-5, feedback high bits 6-0.
// RULE18: Pixel parameters load on delayed bit 1 or immediate bit one then zero.
// RULE19: Synthesizer bit 0 powers down pixel PLL, bit 1 the memory PLL.
// RULE20: Test counter runs while bit 2; bit 3 picks clock; writing bit 4 clears.
// RULE21: Alternate pin floats on bit 5; bits 6 and 7 select external clocks.
// RULE22: Strap bit eleven forces both external clock selects at reset.
// RULE23: Software pulses the immediate-load bit and never leaves it set.
`timescale 1ns/1ns
`include "esc_seq_regs.vh"

module esc_seq_ctrl #(
    parameter CNT_W = 16,
    parameter [7:0] MPLL_LO_RESET = `ESC_RST_MPLL_LO,
    parameter [7:0] MPLL_HI_RESET = `ESC_RST_MPLL_HI
) (
    // Clock, reset and enable.
    input wire core_clk,
    input wire rst,
    input wire clkEn,
    // Sequencer index and data port.
    input wire seqIndexWr,
    input wire seqDataWr,
    input wire seqDataRd,
    input wire [7:0] seqWrData,
    output wire [7:0] seqIndex,
    // Memory-mapped access.
    input wire mmioEnable,
    input wire mmioWr,
    input wire mmioRd,
    input wire [7:0] mmioIndex,
    input wire [7:0] mmioWrData,
    // Read answer for either path.
    output wire [7:0] rdData,
    output wire rdValid,
    // Local memory data bus.
    input wire busOutReq,
    input wire [63:0] busOutData,
    output wire [63:0] memDataOut,
    output wire [63:0] memDataOe,
    // CPU memory write sequencer.
    input wire memWrReq,
    output wire memWrReady,
    output wire memWrActive,
    output wire memWrDone,
    // Feature connector and syncs.
    input wire video_clock_dir_n,
    input wire sync_dir_n,
    input wire hsyncGen,
    input wire vsyncGen,
    output wire feature_port_enable_pin_n,
    output wire videoClockOe,
    output wire syncOe,
    output wire hsyncOut,
    output wire vsyncOut,
    output wire dotSourceExternal,
    output wire featLatchByInput,
    output wire featColor8,
    output wire featColor15,
    output wire featColor16,
    output wire featColorReserved,
    // Clock synthesizer.
    input wire [1:0] miscClockSelect,
    input wire [7:0] vgaPixelLow,
    input wire [7:0] vgaPixelHigh,
    output wire [4:0] memPllN,
    output wire [1:0] memPllR,
    output wire [6:0] memPllM,
    output wire [4:0] pixPllN,
    output wire [2:0] pixPllR,
    output wire [6:0] pixPllM,
    output wire pixPllUseEnhanced,
    output wire memPllLoad,
    output wire pixPllLoad,
    output wire pixel_pll_powerdown,
    output wire memory_pll_powerdown,
    // Test counter and clock select pins.
    input wire pixClockSample,
    input wire memClockSample,
    output wire [CNT_W-1:0] testCount,
    input wire strap_bit_eleven,
    input wire altPinOut,
    output wire altPinData,
    output wire altPinOe,
    output wire memory_clock_external,
    output wire pixel_clock_external
);

    localparam WS_IDLE = 1'b0;
    localparam WS_RUN = 1'b1;
    localparam HOLD_LSB = 29;

    reg [7:0] seqIndex_q;
    reg [7:0] unlock_q, policy_q, memBus_q, featClk_q, featSync_q;
    reg [7:0] mpllLo_q, mpllHi_q, ppllLo_q, ppllHi_q, synth1_q, synth2_q;
    reg [7:0] mpllLoAct_q, mpllHiAct_q, ppllLoAct_q, ppllHiAct_q;
    reg memLoad_q, pixLoad_q;
    reg [7:0] rdData_q;
    reg rdValid_q;
    reg [63:0] memDataOut_q, memDataOe_q;
    reg wrState_q;
    reg [1:0] wrCnt_q;
    reg wrDone_q;
    reg featEnPinN_q, videoClockOe_q, syncOe_q, hsyncOut_q, vsyncOut_q;
    reg color8_q, color15_q, color16_q, colorRes_q;
    reg [CNT_W-1:0] testCount_q;
    reg [3:0] syncA_q, syncB_q;
    reg [1:0] tickPrev_q;
    reg strapA_q, strapB_q;
    reg [7:0] rdMux;

    // Force a field of a sync signal.
    function forceSync;
        input [1:0] code;
        input gen;
        begin
            case (code)
                `ESC_FORCE_LOW: forceSync = 1'b0;
                `ESC_FORCE_HIGH: forceSync = 1'b1;
                default: forceSync = gen;
            endcase
        end
    endfunction

    // Access decode; memory-mapped access wins a tie.
    wire mmioAcc = mmioWr | mmioRd;
    wire [7:0] accIdx = mmioAcc ? mmioIndex : seqIndex_q;
    wire accWr = mmioAcc ? mmioWr : seqDataWr;
    wire accRd = mmioAcc ? mmioRd : seqDataRd;
    wire [7:0] accData = mmioAcc ? mmioWrData : seqWrData;
    wire isExt = (accIdx >= `ESC_IDX_EXT_FIRST) && (accIdx <= `ESC_IDX_EXT_LAST);
    wire portBlocked = ~mmioAcc & mmioEnable & policy_q[`ESC_B_MMIO_EXCLUSIVE_SELECT]; // see RULE2
    wire unlocked = (unlock_q[3:0] == `ESC_UNLOCK_KEY); // see RULE1
    wire extOpen = unlocked | (accIdx == `ESC_IDX_UNLOCK);
    wire accOk = isExt & extOpen & ~portBlocked;
    wire wrOk = accWr & accOk;

    wire wUnlock = wrOk & (accIdx == `ESC_IDX_UNLOCK);
    wire wPolicy = wrOk & (accIdx == `ESC_IDX_POLICY);
    wire wMemBus = wrOk & (accIdx == `ESC_IDX_MEMBUS);
    wire wFeatClk = wrOk & (accIdx == `ESC_IDX_FEATCLK);
    wire wFeatSync = wrOk & (accIdx == `ESC_IDX_FEATSYNC);
    wire wMpllLo = wrOk & (accIdx == `ESC_IDX_MPLL_LO);
    wire wMpllHi = wrOk & (accIdx == `ESC_IDX_MPLL_HI);
    wire wPpllLo = wrOk & (accIdx == `ESC_IDX_PPLL_LO);
    wire wPpllHi = wrOk & (accIdx == `ESC_IDX_PPLL_HI);
    wire wSynth1 = wrOk & (accIdx == `ESC_IDX_SYNTH1);
    wire wSynth2 = wrOk & (accIdx == `ESC_IDX_SYNTH2);

    // Next synth_control_two value, seen by the load logic.
    wire [7:0] synth2Next = wSynth2 ? accData : synth2_q;
    wire memLoadNow = synth2Next[`ESC_B_MEM_LOAD] | synth2Next[`ESC_B_IMM_LOAD]; // see RULE15
    wire immFall = synth2_q[`ESC_B_IMM_LOAD] & ~synth2Next[`ESC_B_IMM_LOAD];
    wire pixLoadNow = synth2Next[`ESC_B_PIX_LOAD] | immFall; // see RULE18
    wire useEnh = (miscClockSelect == 2'h3); // see RULE16
    wire [7:0] pixSrcLo = useEnh ? ppllLo_q : vgaPixelLow;
    wire [7:0] pixSrcHi = useEnh ? ppllHi_q : vgaPixelHigh;

    // Read multiplexer; refused or unmapped reads answer zero.
    always @* begin
        rdMux = 8'h00;
        if (accOk) begin
            case (accIdx)
                `ESC_IDX_UNLOCK: rdMux = unlock_q;
                `ESC_IDX_POLICY: rdMux = policy_q;
                `ESC_IDX_MEMBUS: rdMux = memBus_q;
                `ESC_IDX_FEATCLK: rdMux = featClk_q;
                `ESC_IDX_FEATSYNC: rdMux = featSync_q;
                `ESC_IDX_MPLL_LO: rdMux = mpllLo_q;
                `ESC_IDX_MPLL_HI: rdMux = mpllHi_q;
                `ESC_IDX_PPLL_LO: rdMux = ppllLo_q;
                `ESC_IDX_PPLL_HI: rdMux = ppllHi_q;
                `ESC_IDX_SYNTH1: rdMux = synth1_q;
                `ESC_IDX_SYNTH2: rdMux = synth2_q;
                default: rdMux = 8'h00;
            endcase
        end
    end

    // Pin synchronisers; free of reset so the strap settles while reset is held.
    always @(posedge core_clk) begin
        if (clkEn) begin
            syncA_q <= {memClockSample, pixClockSample, sync_dir_n, video_clock_dir_n};
            syncB_q <= syncA_q;
            strapA_q <= strap_bit_eleven;
            strapB_q <= strapA_q;
        end
    end

    // Register bank and parameter loading.
    always @(posedge core_clk) begin
        if (rst) begin
            seqIndex_q <= `ESC_RST_ZERO;
            unlock_q <= `ESC_RST_ZERO;
            policy_q <= `ESC_RST_ZERO;
            memBus_q <= `ESC_RST_ZERO;
            featClk_q <= `ESC_RST_ZERO;
            featSync_q <= `ESC_RST_ZERO;
            mpllLo_q <= MPLL_LO_RESET & `ESC_MSK_SEVEN; // see RULE12
            mpllHi_q <= MPLL_HI_RESET & `ESC_MSK_SEVEN; // see RULE12
            mpllLoAct_q <= MPLL_LO_RESET & `ESC_MSK_SEVEN;
            mpllHiAct_q <= MPLL_HI_RESET & `ESC_MSK_SEVEN;
            ppllLo_q <= `ESC_RST_ZERO;
            ppllHi_q <= `ESC_RST_ZERO;
            ppllLoAct_q <= `ESC_RST_ZERO;
            ppllHiAct_q <= `ESC_RST_ZERO;
            synth1_q <= {strapB_q, strapB_q, 6'h00}; // see RULE22
            synth2_q <= `ESC_RST_ZERO;
            memLoad_q <= 1'b0;
            pixLoad_q <= 1'b0;
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            if (seqIndexWr) seqIndex_q <= seqWrData;
            if (wUnlock) unlock_q <= accData & `ESC_MSK_UNLOCK; // see RULE1
            if (wPolicy) policy_q <= accData & `ESC_MSK_POLICY;
            if (wMemBus) memBus_q <= accData & `ESC_MSK_MEMBUS;
            if (wFeatClk) featClk_q <= accData & `ESC_MSK_FEATCLK;
            if (wFeatSync) featSync_q <= accData & `ESC_MSK_FEATSYNC;
            if (wMpllLo) mpllLo_q <= accData & `ESC_MSK_SEVEN;
            if (wMpllHi) mpllHi_q <= accData & `ESC_MSK_SEVEN;
            if (wPpllLo) ppllLo_q <= accData;
            if (wPpllHi) ppllHi_q <= accData & `ESC_MSK_SEVEN;
            if (wSynth1) synth1_q <= accData;
            synth2_q <= synth2Next;
            // A memory load takes along values written in the same cycle; a pixel load takes the stored values, or the VGA pixel inputs unless clock select is 11.
            memLoad_q <= memLoadNow;
            if (memLoadNow) begin
                mpllLoAct_q <= wMpllLo ? (accData & `ESC_MSK_SEVEN) : mpllLo_q; // see RULE15
                mpllHiAct_q <= wMpllHi ? (accData & `ESC_MSK_SEVEN) : mpllHi_q;
            end
            pixLoad_q <= pixLoadNow;
            if (pixLoadNow) begin
                ppllLoAct_q <= pixSrcLo; // see RULE18
                ppllHiAct_q <= pixSrcHi & `ESC_MSK_SEVEN;
            end
            rdValid_q <= accRd;
            rdData_q <= rdMux;
        end
    end

    // Local memory data bus drive.
    always @(posedge core_clk) begin
        if (rst) begin
            memDataOut_q <= {64{1'b0}};
            memDataOe_q <= {64{1'b0}};
        end else if (clkEn) begin
            memDataOe_q <= {64{memBus_q[`ESC_B_BUS_KEEP] | busOutReq}}; // see RULE3
            if (busOutReq) begin
                memDataOut_q <= busOutData;
            end else begin
                // Upper lanes keep their last value; lower lanes return to zero.
                memDataOut_q[HOLD_LSB-1:0] <= {HOLD_LSB{1'b0}}; // see RULE4
            end
        end
    end

    // CPU memory write length sequencer.
    always @(posedge core_clk) begin
        if (rst) begin
            wrState_q <= WS_IDLE;
            wrCnt_q <= 2'h0;
            wrDone_q <= 1'b0;
        end else if (clkEn) begin
            wrDone_q <= 1'b0;
            case (wrState_q)
                WS_IDLE: begin
                    if (memWrReq) begin
                        wrState_q <= WS_RUN;
                        wrCnt_q <= memBus_q[`ESC_B_SHORT_WR] ? `ESC_WR_SHORT : `ESC_WR_LONG; // see RULE5
                    end
                end
                WS_RUN: begin
                    if (wrCnt_q == 2'h1) begin
                        wrState_q <= WS_IDLE;
                        wrDone_q <= 1'b1;
                    end else begin
                        wrCnt_q <= wrCnt_q - 2'h1; // see RULE5
                    end
                end
                default: wrState_q <= WS_IDLE;
            endcase
        end
    end

    // Feature connector directions, sync forcing and colour format decode.
    always @(posedge core_clk) begin
        if (rst) begin
            featEnPinN_q <= 1'b1;
            videoClockOe_q <= 1'b1;
            syncOe_q <= 1'b1;
            hsyncOut_q <= 1'b0;
            vsyncOut_q <= 1'b0;
            color8_q <= 1'b1;
            color15_q <= 1'b0;
            color16_q <= 1'b0;
            colorRes_q <= 1'b0;
        end else if (clkEn) begin
            featEnPinN_q <= ~featSync_q[`ESC_B_FEAT_EN]; // see RULE9
            videoClockOe_q <= ~featSync_q[`ESC_B_FEAT_EN] | syncB_q[0];
            syncOe_q <= ~featSync_q[`ESC_B_FEAT_EN] | syncB_q[1];
            hsyncOut_q <= forceSync(featSync_q[5:4], hsyncGen); // see RULE10
            vsyncOut_q <= forceSync(featSync_q[7:6], vsyncGen); // see RULE11
            color8_q <= (featClk_q[7:4] == `ESC_FMT_8); // see RULE8
            color15_q <= (featClk_q[7:4] == `ESC_FMT_15);
            color16_q <= (featClk_q[7:4] == `ESC_FMT_16);
            colorRes_q <= (featClk_q[7:4] != `ESC_FMT_8) && (featClk_q[7:4] != `ESC_FMT_15)
                && (featClk_q[7:4] != `ESC_FMT_16);
        end
    end

    // Test counter of rising edges of the chosen clock sample.
    wire [1:0] tickRise = syncB_q[3:2] & ~tickPrev_q;
    wire tickSel = synth1_q[`ESC_B_CNT_SEL] ? tickRise[1] : tickRise[0]; // see RULE20
    wire cntClear = wSynth1 & accData[`ESC_B_CNT_CLR]; // see RULE20

    always @(posedge core_clk) begin
        if (rst) begin
            tickPrev_q <= 2'h0;
            testCount_q <= {CNT_W{1'b0}};
        end else if (clkEn) begin
            tickPrev_q <= syncB_q[3:2];
            if (cntClear) begin
                testCount_q <= {CNT_W{1'b0}}; // see RULE20
            end else if (synth1_q[`ESC_B_CNT_EN] && tickSel) begin
                testCount_q <= testCount_q + {{(CNT_W-1){1'b0}}, 1'b1}; // see RULE20
            end
        end
    end

    // Output assignments.
    assign seqIndex = seqIndex_q;
    assign rdData = rdData_q;
    assign rdValid = rdValid_q;
    assign memDataOut = memDataOut_q;
    assign memDataOe = memDataOe_q;
    assign memWrReady = (wrState_q == WS_IDLE);
    assign memWrActive = (wrState_q == WS_RUN);
    assign memWrDone = wrDone_q;
    assign feature_port_enable_pin_n = featEnPinN_q;
    assign videoClockOe = videoClockOe_q;
    assign syncOe = syncOe_q;
    assign hsyncOut = hsyncOut_q;
    assign vsyncOut = vsyncOut_q;
    assign dotSourceExternal = featClk_q[`ESC_B_DOT_EXT]; // see RULE6
    assign featLatchByInput = featClk_q[`ESC_B_AFP_LATCH]; // see RULE7
    assign featColor8 = color8_q;
    assign featColor15 = color15_q;
    assign featColor16 = color16_q;
    assign featColorReserved = colorRes_q;
    assign memPllN = mpllLoAct_q[4:0]; // see RULE13
    assign memPllR = mpllLoAct_q[6:5]; // see RULE14
    assign memPllM = mpllHiAct_q[6:0]; // see RULE13
    assign pixPllN = ppllLoAct_q[4:0]; // see RULE17
    assign pixPllR = ppllLoAct_q[7:5];
    assign pixPllM = ppllHiAct_q[6:0];
    assign pixPllUseEnhanced = useEnh;
    assign memPllLoad = memLoad_q;
    assign pixPllLoad = pixLoad_q;
    assign pixel_pll_powerdown = synth1_q[`ESC_B_PIX_PD]; // see RULE19
    assign memory_pll_powerdown = synth1_q[`ESC_B_MEM_PD]; // see RULE19
    assign testCount = testCount_q;
    assign altPinData = altPinOut;
    assign altPinOe = ~synth1_q[`ESC_B_ALT_FLOAT]; // see RULE21
    assign memory_clock_external = synth1_q[`ESC_B_MEM_EXT]; // see RULE21
    assign pixel_clock_external = synth1_q[`ESC_B_PIX_EXT]; // see RULE21

endmodule // esc_seq_ctrl

// *** tb/esc_seq_checker.sv ***
// Purpose: Port assertions for the sequencer bank.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes: Bound to every instance below.
`timescale 1ns/1ns
module esc_seq_checker (
    // Clock, reset and register access.
    input wire core_clk, rst, clkEn, seqDataRd, mmioRd, mmioEnable, rdValid,
    // Memory bus and write sequencer.
    input wire busOutReq, memWrReq, memWrReady, memWrActive, memWrDone,
    input wire [63:0] busOutData, memDataOut, memDataOe,
    // Feature port, clock selects and strap.
    input wire feature_port_enable_pin_n, videoClockOe, syncOe, pixPllUseEnhanced,
    input wire memPllLoad, pixPllLoad, strap_bit_eleven, memory_clock_external,
    input wire pixel_clock_external,
    input wire [1:0] miscClockSelect, memPllR,
    input wire [2:0] pixPllR,
    input wire [4:0] memPllN, pixPllN,
    input wire [6:0] memPllM, pixPllM
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rdv; rdValid == $past((seqDataRd || mmioRd) && clkEn); endproperty
    property p_oe; busOutReq && clkEn |=> memDataOe == {64{1'b1}} &&
        memDataOut == $past(busOutData); endproperty
    property p_hold; !busOutReq && clkEn |=> memDataOut[28:0] == 29'h0 &&
        memDataOut[63:29] == $past(memDataOut[63:29]); endproperty
    property p_wr; memWrReq && memWrReady && clkEn |=> memWrActive[*2] ##[1:2] memWrDone;
    endproperty
    property p_feat; feature_port_enable_pin_n |-> videoClockOe && syncOe; endproperty
    property p_sel; pixPllUseEnhanced == (miscClockSelect == 2'h3); endproperty
    property p_mld; $changed({memPllN, memPllR, memPllM}) |-> ##[0:1] memPllLoad; endproperty
    property p_pld; $changed({pixPllN, pixPllR, pixPllM}) |-> ##[0:1] pixPllLoad; endproperty
    // Strap held through both sync stages during reset.
    property p_strap; disable iff (1'b0) rst && $past(rst, 3) && strap_bit_eleven &&
        $past(strap_bit_eleven, 3) && $past(strap_bit_eleven, 2) |->
        memory_clock_external && pixel_clock_external; endproperty
    a_rdv: assert property (p_rdv) else $error("read answer timing wrong");
    a_oe: assert property (p_oe) else $error("bus not driven on request");
    a_hold: assert property (p_hold) else $error("upper bus bits not held");
    a_wr: assert property (p_wr) else $error("memory write length wrong");
    a_feat: assert property (p_feat) else $error("feature pins not outputs");
    a_sel: assert property (p_sel) else $error("pixel source select wrong");
    a_mld: assert property (p_mld) else $error("memory PLL changed unloaded");
    a_pld: assert property (p_pld) else $error("pixel PLL changed unloaded");
    a_strap: assert property (p_strap) else $error("strap not applied");
    c_wr: cover property (memWrDone);
    c_mmio: cover property (mmioRd && mmioEnable);
    c_pld: cover property ($rose(pixPllLoad));
endmodule // esc_seq_checker

bind esc_seq_ctrl esc_seq_checker i_esc_seq_checker (.*);

// *** tb/esc_host_model.sv ***
// Purpose: Host CPU model for port and memory-mapped register cycles.
// Assumes: Requests change 1 ns after a rising edge of core_clk.
// Notes: Data lines show the inverse of the last value once released.
`timescale 1ns/1ns
module esc_host_model (
    // Clock and read answer.
    input wire core_clk,
    input wire [7:0] rdData,
    input wire rdValid,
    // Requests.
    output logic seqIndexWr, seqDataWr, seqDataRd, mmioWr, mmioRd,
    output logic [7:0] seqWrData, mmioIndex, mmioWrData
);
    initial begin
        {seqIndexWr, seqDataWr, seqDataRd, mmioWr, mmioRd, seqWrData, mmioIndex, mmioWrData} = 29'h0;
    end
    // One access; the port path loads the index one cycle before the data cycle.
    task automatic acc(input mm, input wr, input [7:0] idx, input [7:0] wd,
            output [7:0] rd, output ok);
        @(posedge core_clk);
        #1;
        if (mm) begin
            {mmioIndex, mmioWrData, mmioWr, mmioRd} = {idx, wd, wr, !wr};
        end else begin
            {seqWrData, seqIndexWr} = {idx, 1'b1};
            @(posedge core_clk);
            #1;
            {seqIndexWr, seqWrData, seqDataWr, seqDataRd} = {1'b0, wd, wr, !wr};
        end
        @(posedge core_clk);
        #1;
        {rd, ok} = {rdData, rdValid};
        {seqDataWr, seqDataRd, mmioWr, mmioRd} = 4'h0;
        {seqWrData, mmioWrData} = ~{seqWrData, mmioWrData};
    endtask
endmodule // esc_host_model

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the extended sequencer register bank.
// Assumes: Inputs change 1 ns after a rising clock edge.
// Notes: One task per scenario.
`timescale 1ns/1ns
`include "esc_seq_regs.vh"
module tb;
    logic core_clk, rst, clkEn, mmioEnable, busOutReq, memWrReq, video_clock_dir_n;
    logic sync_dir_n, hsyncGen, vsyncGen, pixClockSample, memClockSample, strap_bit_eleven;
    logic altPinOut, seqIndexWr, seqDataWr, seqDataRd, mmioWr, mmioRd, rdValid, v;
    logic memWrReady, memWrActive, memWrDone, feature_port_enable_pin_n, videoClockOe;
    logic syncOe, hsyncOut, vsyncOut, dotSourceExternal, featLatchByInput, featColor8;
    logic featColor15, featColor16, featColorReserved, pixPllUseEnhanced, memPllLoad;
    logic pixPllLoad, pixel_pll_powerdown, memory_pll_powerdown, altPinData, altPinOe;
    logic memory_clock_external, pixel_clock_external;
    logic [1:0] miscClockSelect, memPllR;
    logic [2:0] pixPllR;
    logic [4:0] memPllN, pixPllN;
    logic [6:0] memPllM, pixPllM;
    logic [7:0] seqWrData, mmioIndex, mmioWrData, seqIndex, rdData, vgaPixelLow, vgaPixelHigh;
    logic [7:0] r8;
    logic [15:0] testCount;
    logic [63:0] busOutData, memDataOut, memDataOe;
    int failures = 0;
    int checks_done = 0;
    int n;
    esc_seq_ctrl i_esc_seq_ctrl (.*);
    esc_host_model i_esc_host_model (.*);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input [63:0] got, input [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input mm, input [7:0] i, input [7:0] d);
        i_esc_host_model.acc(mm, 1'b1, i, d, r8, v);
    endtask
    task automatic rdchk(input mm, input [7:0] i, input [7:0] e);
        i_esc_host_model.acc(mm, 1'b0, i, 8'h00, r8, v);
        chk(v, 1'b1);
        chk(r8, e);
    endtask
    task stop_test;
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task t_lock;
        wr(0, 8'h0A, 8'hFF);
        rdchk(0, 8'h0A, 8'h00);
        wr(0, 8'h08, 8'hF6);
        rdchk(0, 8'h08, 8'h06);
        rdchk(0, 8'h10, 8'h21);
        chk({memPllN, memPllR, memPllM}, {5'h01, 2'h1, 7'h3F});
        wr(0, 8'h0A, 8'hFF);
        rdchk(0, 8'h0A, 8'hA0);
        wr(0, 8'h0B, 8'hFF);
        rdchk(0, 8'h0B, 8'hF3);
    endtask
    task t_mmio;
        mmioEnable = 1'b1;
        wr(0, 8'h09, 8'h80);
        rdchk(0, 8'h0A, 8'h00);
        rdchk(1, 8'h0A, 8'hA0);
        wr(1, 8'h09, 8'h00);
        rdchk(0, 8'h0A, 8'hA0);
        mmioEnable = 1'b0;
    endtask
    task t_bus;
        chk(memDataOe, {64{1'b1}});
        wr(0, 8'h0A, 8'h00);
        busOutReq = 1'b1;
        busOutData = 64'hAAAA_5555_F0F0_0F0F;
        cyc(1);
        chk(memDataOut, 64'hAAAA_5555_F0F0_0F0F);
        busOutReq = 1'b0;
        busOutData = 64'h5555_AAAA_0F0F_F0F0;
        cyc(1);
        chk(memDataOe, 64'h0);
        chk(memDataOut, 64'hAAAA_5555_E000_0000);
    endtask
    task t_write;
        for (int s = 0; s < 2; s++) begin
            wr(0, 8'h0A, s ? 8'h80 : 8'h00);
            memWrReq = 1'b1;
            cyc(1);
            memWrReq = 1'b0;
            n = 0;
            repeat (5) begin
                n += memWrActive;
                cyc(1);
            end
            chk(n, s ? 2 : 3);
        end
    endtask
    task t_sync;
        for (int c = 0; c < 3; c++) begin
            wr(0, 8'h0D, {c[1:0], c[1:0], 4'h0});
            for (int g = 1; g >= 0; g--) begin
                {hsyncGen, vsyncGen} = {g[0], g[0]};
                cyc(2);
                chk(hsyncOut, c == 0 ? g[0] : c == 2);
                chk(vsyncOut, c == 0 ? g[0] : c == 2);
            end
        end
        video_clock_dir_n = 1'b0;
        wr(0, 8'h0D, 8'h01);
        cyc(3);
        chk({feature_port_enable_pin_n, videoClockOe, syncOe}, 3'b001);
        wr(0, 8'h0D, 8'h00);
        cyc(1);
        chk({feature_port_enable_pin_n, videoClockOe, syncOe}, 3'b111);
    endtask
    task t_feat;
        logic [3:0] code [4] = '{4'h0, 4'h3, 4'h5, 4'h9};
        for (int k = 0; k < 4; k++) begin
            wr(0, 8'h0B, {code[k], 4'h3});
            cyc(1);
            chk({featColor8, featColor15, featColor16, featColorReserved}, 4'h8 >> k);
            chk({dotSourceExternal, featLatchByInput}, 2'b11);
        end
    endtask
    task t_pll;
        wr(0, 8'h10, 8'h45);
        wr(0, 8'h11, 8'h50);
        chk(memPllN, 5'h01);
        miscClockSelect = 2'h3;
        wr(0, 8'h12, 8'hA7);
        wr(0, 8'h13, 8'h33);
        wr(0, 8'h15, 8'h20);
        wr(0, 8'h15, 8'h00);
        chk({memPllN, memPllR, memPllM}, {5'h05, 2'h2, 7'h50});
        chk({pixPllN, pixPllR, pixPllM}, {5'h07, 3'h5, 7'h33});
        {miscClockSelect, vgaPixelLow, vgaPixelHigh} = {2'h0, 8'h2C, 8'h11};
        wr(0, 8'h15, 8'h02);
        wr(0, 8'h15, 8'h00);
        chk({pixPllN, pixPllR, pixPllM}, {5'h0C, 3'h1, 7'h11});
    endtask
    task t_synth;
        wr(0, 8'h14, 8'hE3);
        chk({pixel_pll_powerdown, memory_pll_powerdown, altPinOe}, 3'b110);
        chk({memory_clock_external, pixel_clock_external, altPinData}, 3'b111);
        for (int m = 0; m < 3; m++) begin
            wr(0, 8'h14, m == 0 ? 8'h0C : 8'h18);
            repeat (4) begin
                {memClockSample, pixClockSample} = 2'b11;
                cyc(2);
                {memClockSample, pixClockSample} = 2'b00;
                cyc(2);
            end
            cyc(4);
            chk(testCount, m == 0 ? 16'h4 : 16'h0);
        end
    endtask
    initial begin
        {rst, clkEn, mmioEnable, busOutReq, memWrReq, hsyncGen, vsyncGen} = 7'b1100000;
        {video_clock_dir_n, sync_dir_n, pixClockSample, memClockSample} = 4'b1100;
        {strap_bit_eleven, altPinOut, miscClockSelect} = 4'b0100;
        {vgaPixelLow, vgaPixelHigh, busOutData} = 80'h0;
        cyc(10);
        rst = 1'b0;
        t_lock();
        t_mmio();
        t_bus();
        t_write();
        t_sync();
        t_feat();
        t_pll();
        t_synth();
        strap_bit_eleven = 1'b1;
        rst = 1'b1;
        cyc(5);
        rst = 1'b0;
        chk({memory_clock_external, pixel_clock_external}, 2'b11);
        stop_test();
    end
endmodule // tb
